// >>> rtl/ssr_top.sv
`timescale 1ns/1ps
// How it works
// - SRQ asserted when an enabled status byte bit starts to request service, until a serial poll or the request ends.
// - Host writes enable mask as a binary weighted value, e.g. 16 enables bit 4.
// - Enable mask query returns the stored weighted sum, mask untouched.
// - Operation and questionable groups 16 bits; status byte and standard event 8.
// - Top bit of every 16-bit group is always zero.
// - Message-available bit follows output queue non-empty one clock later.
// - Clearing an event register clears the summary bit it feeds.
// - Message-available clears once output queue is empty.
// - Status byte bit 0 always reads zero.
// - Bit 1 is the device status group summary.
// - Bit 2 shows error queue non-empty.
// - Bit 3 is the questionable group summary.
// - Bit 5 is the standard event group summary.
// - Bit 6 shows the device is requesting service.
// - Bit 7 is the operation group summary.
// - Reading an event register clears it and so its summary bit.
// - Enable mask cleared at power-up or on writing zero.
// - Status byte query returns serial poll byte without clearing bit 6.
// - Status byte query runs in order, only after prior commands finish.
// - Status byte query leaves the status byte unchanged.
// - Group summary is OR of event AND enable.
// - Event bits latch until read or clear-status.
module ssr_top #(
	parameter int DEV_W = 16,
	parameter int QUES_W = 16,
	parameter int OPER_W = 16,
	parameter int STD_W = 8
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic [DEV_W-1:0] i_dev_cond,
	input wire logic [QUES_W-1:0] i_ques_cond,
	input wire logic [OPER_W-1:0] i_oper_cond,
	input wire logic [STD_W-1:0] i_std_cond,
	input wire logic i_errq_nonempty,
	input wire logic i_outq_nonempty,
	input wire logic i_cmd_valid,
	input wire ssr_pkg::ssr_op_t i_cmd_op,
	input wire ssr_pkg::ssr_grp_t i_cmd_grp,
	input wire logic [15:0] i_cmd_data,
	input wire logic i_prior_done,
	output logic o_cmd_ready,
	output logic o_resp_valid,
	output logic [15:0] o_resp_data,
	input wire logic i_spoll,
	output logic o_spoll_valid,
	output logic [7:0] o_spoll_data,
	output logic [7:0] o_status_byte,
	output logic o_srq
);

	localparam int RW = ssr_pkg::RESP_W;

	// refused at elaboration, before any logic is built
	if (QUES_W != ssr_pkg::WIDE_GRP_W || OPER_W != ssr_pkg::WIDE_GRP_W) begin : g_chk_wide
		$error("questionable and operation groups must be 16 bits");
	end
	if (STD_W != ssr_pkg::NARROW_GRP_W) begin : g_chk_narrow
		$error("standard event group must be 8 bits");
	end
	if (DEV_W < 2 || DEV_W > ssr_pkg::WIDE_GRP_W) begin : g_chk_dev
		$error("device status group width out of range");
	end

	function automatic logic grp_op(input ssr_pkg::ssr_op_t op, input ssr_pkg::ssr_grp_t grp,
			input ssr_pkg::ssr_op_t want, input ssr_pkg::ssr_grp_t which);
		grp_op = (op == want) && (grp == which);
	endfunction

	logic take;
	logic cls;
	logic preset;
	logic [3:0] clr_g;
	logic [3:0] en_we_g;
	logic [3:0] ptr_we_g;
	logic [3:0] ntr_we_g;

	logic [DEV_W-1:0] dev_cond, dev_evt, dev_en;
	logic [QUES_W-1:0] ques_cond, ques_evt, ques_en;
	logic [OPER_W-1:0] oper_cond, oper_evt, oper_en;
	logic [STD_W-1:0] std_cond, std_evt, std_en;
	logic dev_sum, ques_sum, oper_sum, std_sum;

	logic [7:0] sre_r, sre_nxt;
	logic [7:0] stb_live;
	logic [7:0] stb_full;
	logic req;
	logic rqs;

	logic resp_valid_r, resp_valid_nxt;
	logic [15:0] resp_data_r, resp_data_nxt;
	logic spoll_valid_r, spoll_valid_nxt;
	logic [7:0] spoll_data_r, spoll_data_nxt;
	logic [7:0] stb_r, stb_nxt;

	// gated on prior completion so a status query never overtakes queued work
	assign o_cmd_ready = i_ce & i_prior_done;
	assign take = i_cmd_valid & o_cmd_ready;

	always_comb begin
		cls = take && (i_cmd_op == ssr_pkg::OP_CLS);
		preset = take && (i_cmd_op == ssr_pkg::OP_PRESET);
		for (int g = 0; g < 4; g++) begin
			clr_g[g] = cls || (take && grp_op(i_cmd_op, i_cmd_grp, ssr_pkg::OP_EVT_RD,
				ssr_pkg::ssr_grp_t'(g)));
			en_we_g[g] = take && grp_op(i_cmd_op, i_cmd_grp, ssr_pkg::OP_EN_WR,
				ssr_pkg::ssr_grp_t'(g));
			ptr_we_g[g] = take && grp_op(i_cmd_op, i_cmd_grp, ssr_pkg::OP_PTR_WR,
				ssr_pkg::ssr_grp_t'(g));
			ntr_we_g[g] = take && grp_op(i_cmd_op, i_cmd_grp, ssr_pkg::OP_NTR_WR,
				ssr_pkg::ssr_grp_t'(g));
		end
	end

	ssr_group #(
		.W(DEV_W),
		.TOP_UNUSED(DEV_W == ssr_pkg::WIDE_GRP_W)
	) u_dev (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_cond(i_dev_cond),
		.i_clr(clr_g[ssr_pkg::GRP_DEV]),
		.i_en_we(en_we_g[ssr_pkg::GRP_DEV]),
		.i_ptr_we(ptr_we_g[ssr_pkg::GRP_DEV]),
		.i_ntr_we(ntr_we_g[ssr_pkg::GRP_DEV]),
		.i_preset(preset),
		.i_wdata(i_cmd_data[DEV_W-1:0]),
		.o_cond(dev_cond),
		.o_event(dev_evt),
		.o_enable(dev_en),
		.o_summary(dev_sum)
	);

	ssr_group #(
		.W(QUES_W),
		.TOP_UNUSED(1'b1)
	) u_ques (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_cond(i_ques_cond),
		.i_clr(clr_g[ssr_pkg::GRP_QUES]),
		.i_en_we(en_we_g[ssr_pkg::GRP_QUES]),
		.i_ptr_we(ptr_we_g[ssr_pkg::GRP_QUES]),
		.i_ntr_we(ntr_we_g[ssr_pkg::GRP_QUES]),
		.i_preset(preset),
		.i_wdata(i_cmd_data[QUES_W-1:0]),
		.o_cond(ques_cond),
		.o_event(ques_evt),
		.o_enable(ques_en),
		.o_summary(ques_sum)
	);

	ssr_group #(
		.W(OPER_W),
		.TOP_UNUSED(1'b1)
	) u_oper (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_cond(i_oper_cond),
		.i_clr(clr_g[ssr_pkg::GRP_OPER]),
		.i_en_we(en_we_g[ssr_pkg::GRP_OPER]),
		.i_ptr_we(ptr_we_g[ssr_pkg::GRP_OPER]),
		.i_ntr_we(ntr_we_g[ssr_pkg::GRP_OPER]),
		.i_preset(preset),
		.i_wdata(i_cmd_data[OPER_W-1:0]),
		.o_cond(oper_cond),
		.o_event(oper_evt),
		.o_enable(oper_en),
		.o_summary(oper_sum)
	);

	// standard event filters are left at rising-edge only; preset does not touch them
	ssr_group #(
		.W(STD_W),
		.TOP_UNUSED(1'b0)
	) u_std (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_cond(i_std_cond),
		.i_clr(clr_g[ssr_pkg::GRP_STD]),
		.i_en_we(en_we_g[ssr_pkg::GRP_STD]),
		.i_ptr_we(1'b0),
		.i_ntr_we(1'b0),
		.i_preset(1'b0),
		.i_wdata(i_cmd_data[STD_W-1:0]),
		.o_cond(std_cond),
		.o_event(std_evt),
		.o_enable(std_en),
		.o_summary(std_sum)
	);

	// summary bits are derived, so clearing an event clears its summary at once
	always_comb begin
		stb_live = 8'h00;
		stb_live[ssr_pkg::STB_UNUSED] = 1'b0;
		stb_live[ssr_pkg::STB_DEV] = dev_sum;
		stb_live[ssr_pkg::STB_ERRQ] = i_errq_nonempty;
		stb_live[ssr_pkg::STB_QUES] = ques_sum;
		stb_live[ssr_pkg::STB_MAV] = i_outq_nonempty;
		stb_live[ssr_pkg::STB_ESB] = std_sum;
		stb_live[ssr_pkg::STB_OPER] = oper_sum;
		// bit 6 of the mask cannot feed itself
		req = |(stb_live & sre_r & ~(8'h01 << ssr_pkg::STB_RQS));
		stb_full = stb_live;
		stb_full[ssr_pkg::STB_RQS] = rqs;
	end

	ssr_rqs u_rqs (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_req(req),
		.i_spoll(i_spoll),
		.o_rqs(rqs)
	);

	always_comb begin
		sre_nxt = sre_r;
		// a written zero clears the mask like any other value would be stored
		if (take && i_cmd_op == ssr_pkg::OP_SRE_WR) begin
			sre_nxt = i_cmd_data[7:0];
		end
	end

	always_comb begin
		resp_valid_nxt = 1'b0;
		resp_data_nxt = ssr_pkg::RESP_RST;
		if (take) begin
			case (i_cmd_op)
				ssr_pkg::OP_SRE_RD: begin
					resp_valid_nxt = 1'b1;
					resp_data_nxt = RW'(sre_r);
				end
				ssr_pkg::OP_STB_RD: begin
					// same byte as a poll, but rqs and all summaries stay as they are
					resp_valid_nxt = 1'b1;
					resp_data_nxt = RW'(stb_full);
				end
				ssr_pkg::OP_EVT_RD: begin
					resp_valid_nxt = 1'b1;
					case (i_cmd_grp)
						ssr_pkg::GRP_DEV: resp_data_nxt = RW'(dev_evt);
						ssr_pkg::GRP_QUES: resp_data_nxt = RW'(ques_evt);
						ssr_pkg::GRP_OPER: resp_data_nxt = RW'(oper_evt);
						default: resp_data_nxt = RW'(std_evt);
					endcase
				end
				ssr_pkg::OP_COND_RD: begin
					resp_valid_nxt = 1'b1;
					case (i_cmd_grp)
						ssr_pkg::GRP_DEV: resp_data_nxt = RW'(dev_cond);
						ssr_pkg::GRP_QUES: resp_data_nxt = RW'(ques_cond);
						ssr_pkg::GRP_OPER: resp_data_nxt = RW'(oper_cond);
						default: resp_data_nxt = RW'(std_cond);
					endcase
				end
				ssr_pkg::OP_EN_RD: begin
					resp_valid_nxt = 1'b1;
					case (i_cmd_grp)
						ssr_pkg::GRP_DEV: resp_data_nxt = RW'(dev_en);
						ssr_pkg::GRP_QUES: resp_data_nxt = RW'(ques_en);
						ssr_pkg::GRP_OPER: resp_data_nxt = RW'(oper_en);
						default: resp_data_nxt = RW'(std_en);
					endcase
				end
				default: begin
					resp_valid_nxt = 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		spoll_valid_nxt = i_spoll;
		spoll_data_nxt = spoll_data_r;
		if (i_spoll) begin
			spoll_data_nxt = stb_full;
		end
		stb_nxt = stb_full;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			sre_r <= ssr_pkg::SRE_RST;
			resp_valid_r <= 1'b0;
			resp_data_r <= ssr_pkg::RESP_RST;
			spoll_valid_r <= 1'b0;
			spoll_data_r <= 8'h00;
			stb_r <= 8'h00;
		end else if (i_ce) begin
			sre_r <= sre_nxt;
			resp_valid_r <= resp_valid_nxt;
			resp_data_r <= resp_data_nxt;
			spoll_valid_r <= spoll_valid_nxt;
			spoll_data_r <= spoll_data_nxt;
			stb_r <= stb_nxt;
		end
	end

	assign o_resp_valid = resp_valid_r;
	assign o_resp_data = resp_data_r;
	assign o_spoll_valid = spoll_valid_r;
	assign o_spoll_data = spoll_data_r;
	assign o_status_byte = stb_r;
	assign o_srq = rqs;

endmodule // ssr_top

// >>> rtl/ssr_pkg.sv
package ssr_pkg;

	// status byte bit positions
	localparam int STB_W = 8;
	localparam int STB_UNUSED = 0;
	localparam int STB_DEV = 1;
	localparam int STB_ERRQ = 2;
	localparam int STB_QUES = 3;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_RQS = 6;
	localparam int STB_OPER = 7;

	// group widths
	localparam int WIDE_GRP_W = 16;
	localparam int NARROW_GRP_W = 8;
	localparam int RESP_W = 16;

	// values after reset; preset also loads EN_RST, PTR_RST and NTR_RST
	localparam logic [7:0] SRE_RST = 8'h00;
	localparam logic [15:0] EN_RST = 16'h0000;
	localparam logic [15:0] PTR_RST = 16'hFFFF;
	localparam logic [15:0] NTR_RST = 16'h0000;
	localparam logic [15:0] COND_RST = 16'h0000;
	localparam logic [15:0] EVT_RST = 16'h0000;
	localparam logic [15:0] RESP_RST = 16'h0000;

	typedef enum logic [1:0] {
		GRP_DEV = 2'h0,
		GRP_QUES = 2'h1,
		GRP_OPER = 2'h2,
		GRP_STD = 2'h3
	} ssr_grp_t;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_CLS = 4'h1,
		OP_SRE_WR = 4'h2,
		OP_SRE_RD = 4'h3,
		OP_STB_RD = 4'h4,
		OP_EVT_RD = 4'h5,
		OP_COND_RD = 4'h6,
		OP_EN_WR = 4'h7,
		OP_EN_RD = 4'h8,
		OP_PTR_WR = 4'h9,
		OP_NTR_WR = 4'hA,
		OP_PRESET = 4'hB
	} ssr_op_t;

endpackage

// >>> rtl/ssr_group.sv
`timescale 1ns/1ps
module ssr_group #(
	parameter int W = 16,
	parameter bit TOP_UNUSED = 1'b1
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic [W-1:0] i_cond,
	input wire logic i_clr,
	input wire logic i_en_we,
	input wire logic i_ptr_we,
	input wire logic i_ntr_we,
	input wire logic i_preset,
	input wire logic [W-1:0] i_wdata,
	output logic [W-1:0] o_cond,
	output logic [W-1:0] o_event,
	output logic [W-1:0] o_enable,
	output logic o_summary
);

	// refused at elaboration, before any logic is built
	if (W < 2 || W > ssr_pkg::WIDE_GRP_W) begin : g_chk_width
		$error("ssr_group width out of range");
	end

	localparam logic [W-1:0] LIVE = TOP_UNUSED ? {1'b0, {(W-1){1'b1}}} : {W{1'b1}};

	logic [W-1:0] cond_r, cond_nxt;
	logic [W-1:0] evt_r, evt_nxt;
	logic [W-1:0] en_r, en_nxt;
	logic [W-1:0] ptr_r, ptr_nxt;
	logic [W-1:0] ntr_r, ntr_nxt;
	logic [W-1:0] cond_live;
	logic [W-1:0] hit;

	always_comb begin
		cond_live = i_cond & LIVE;
		hit = (cond_live & ~cond_r & ptr_r) | (~cond_live & cond_r & ntr_r);
		cond_nxt = cond_live;
		// latched bits ignore the condition until cleared; a new hit beats the clear
		evt_nxt = ((i_clr ? ssr_pkg::EVT_RST[W-1:0] : evt_r) | hit) & LIVE;
		en_nxt = en_r;
		ptr_nxt = ptr_r;
		ntr_nxt = ntr_r;
		if (i_preset) begin
			en_nxt = ssr_pkg::EN_RST[W-1:0];
			ptr_nxt = ssr_pkg::PTR_RST[W-1:0];
			ntr_nxt = ssr_pkg::NTR_RST[W-1:0];
		end
		if (i_en_we) begin
			en_nxt = i_wdata & LIVE;
		end
		if (i_ptr_we) begin
			ptr_nxt = i_wdata & LIVE;
		end
		if (i_ntr_we) begin
			ntr_nxt = i_wdata & LIVE;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cond_r <= ssr_pkg::COND_RST[W-1:0];
			evt_r <= ssr_pkg::EVT_RST[W-1:0];
			en_r <= ssr_pkg::EN_RST[W-1:0];
			ptr_r <= ssr_pkg::PTR_RST[W-1:0];
			ntr_r <= ssr_pkg::NTR_RST[W-1:0];
		end else if (i_ce) begin
			cond_r <= cond_nxt;
			evt_r <= evt_nxt;
			en_r <= en_nxt;
			ptr_r <= ptr_nxt;
			ntr_r <= ntr_nxt;
		end
	end

	assign o_cond = cond_r;
	assign o_event = evt_r;
	assign o_enable = en_r;
	assign o_summary = |(evt_r & en_r);

endmodule // ssr_group

// >>> rtl/ssr_rqs.sv
`timescale 1ns/1ps
module ssr_rqs (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_req,
	input wire logic i_spoll,
	output logic o_rqs
);

	logic req_prev_r, req_prev_nxt;
	logic rqs_r, rqs_nxt;

	always_comb begin
		req_prev_nxt = i_req;
		// a fresh reason beats the poll clear; rqs drops when no reason is left
		rqs_nxt = ((i_spoll ? 1'b0 : rqs_r) & i_req) | (i_req & ~req_prev_r);
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			req_prev_r <= 1'b0;
			rqs_r <= 1'b0;
		end else if (i_ce) begin
			req_prev_r <= req_prev_nxt;
			rqs_r <= rqs_nxt;
		end
	end

	assign o_rqs = rqs_r;

endmodule // ssr_rqs

// >>> dv/ssr_monitor.sv
`timescale 1ns/1ps
module ssr_monitor (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_errq_nonempty,
	input wire logic i_outq_nonempty,
	input wire logic i_cmd_valid,
	input wire ssr_pkg::ssr_op_t i_cmd_op,
	input wire logic i_prior_done,
	input wire logic o_cmd_ready,
	input wire logic o_resp_valid,
	input wire logic [15:0] o_resp_data,
	input wire logic i_spoll,
	input wire logic o_spoll_valid,
	input wire logic [7:0] o_spoll_data,
	input wire logic [7:0] o_status_byte,
	input wire logic o_srq
);
	logic rd_op;
	always_comb begin
		rd_op = i_cmd_op inside {ssr_pkg::OP_SRE_RD, ssr_pkg::OP_STB_RD, ssr_pkg::OP_EVT_RD,
			ssr_pkg::OP_COND_RD, ssr_pkg::OP_EN_RD};
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	sequence s_take;
		i_cmd_valid && o_cmd_ready;
	endsequence
	sequence s_poll;
		i_spoll && i_ce;
	endsequence
	a_ready_gate: assert property (o_cmd_ready == (i_ce && i_prior_done))
		else $error("ready not gated");
	a_bit0_zero: assert property (!o_status_byte[0] && !o_spoll_data[0])
		else $error("bit 0 set");
	a_mav_follow: assert property ($past(i_ce) |-> o_status_byte[4] == $past(i_outq_nonempty))
		else $error("mav wrong");
	a_errq_follow: assert property ($past(i_ce) |-> o_status_byte[2] == $past(i_errq_nonempty))
		else $error("errq bit wrong");
	a_read_answers: assert property (s_take ##0 rd_op |=> o_resp_valid)
		else $error("no read answer");
	a_write_silent: assert property (s_take ##0 !rd_op |=> !o_resp_valid)
		else $error("answer to write");
	a_top_zero: assert property (o_resp_valid |-> !o_resp_data[15])
		else $error("bit 15 set");
	a_poll_release: assert property (s_poll ##0 o_srq |=> o_spoll_valid && o_spoll_data[6] && !o_srq)
		else $error("poll did not release");
	a_srq_cause: assert property ($rose(o_srq) |-> ((o_status_byte | $past(o_status_byte)) & 8'hBE) != 8'h00)
		else $error("srq without cause");
endmodule // ssr_monitor

bind ssr_top ssr_monitor u_mon (.i_clock, .i_nrst, .i_ce, .i_errq_nonempty, .i_outq_nonempty,
	.i_cmd_valid, .i_cmd_op, .i_prior_done, .o_cmd_ready, .o_resp_valid, .o_resp_data, .i_spoll,
	.o_spoll_valid, .o_spoll_data, .o_status_byte, .o_srq);

// >>> dv/ssr_host_model.sv
`timescale 1ns/1ps
module ssr_host_model (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_arm,
	input wire logic [3:0] i_delay,
	input wire logic i_srq,
	input wire logic i_spoll_valid,
	output logic o_spoll
);
	logic [3:0] wait_r;
	logic busy_r;
	// busy until the answer lands, else the stale srq would poll twice
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_r <= 4'h0;
			busy_r <= 1'b0;
			o_spoll <= 1'b0;
		end else begin
			o_spoll <= 1'b0;
			if (busy_r) begin
				busy_r <= !i_spoll_valid;
			end else if (i_arm && i_srq) begin
				if (wait_r == i_delay) begin
					o_spoll <= 1'b1;
					busy_r <= 1'b1;
					wait_r <= 4'h0;
				end else begin
					wait_r <= wait_r + 4'h1;
				end
			end else begin
				wait_r <= 4'h0;
			end
		end
	end
endmodule // ssr_host_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic i_clock, i_nrst, i_ce, i_cmd_valid, i_prior_done, i_errq_nonempty, i_outq_nonempty;
	logic [15:0] i_dev_cond, i_ques_cond, i_oper_cond, i_cmd_data, o_resp_data;
	logic [7:0] i_std_cond, o_spoll_data, o_status_byte;
	logic o_cmd_ready, o_resp_valid, i_spoll, o_spoll_valid, o_srq, arm;
	logic [3:0] dly;
	ssr_pkg::ssr_op_t i_cmd_op;
	ssr_pkg::ssr_grp_t i_cmd_grp;
	int miscompares, tests_run, cycles;
	int sb [4] = '{1, 3, 7, 5};

	ssr_top DUT (.i_clock, .i_nrst, .i_ce, .i_dev_cond, .i_ques_cond, .i_oper_cond, .i_std_cond,
		.i_errq_nonempty, .i_outq_nonempty, .i_cmd_valid, .i_cmd_op, .i_cmd_grp, .i_cmd_data,
		.i_prior_done, .o_cmd_ready, .o_resp_valid, .o_resp_data, .i_spoll, .o_spoll_valid,
		.o_spoll_data, .o_status_byte, .o_srq);
	ssr_host_model host (.i_clock, .i_nrst, .i_arm(arm), .i_delay(dly), .i_srq(o_srq),
		.i_spoll_valid(o_spoll_valid), .o_spoll(i_spoll));

	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end

	task automatic complete_run;
		$display("Checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge i_clock);
	endtask

	// hold the request until the edge that takes it
	task automatic cmd(ssr_pkg::ssr_op_t op, int g, logic [15:0] d);
		@(posedge i_clock);
		i_cmd_valid <= 1'b1;
		i_cmd_op <= op;
		i_cmd_grp <= ssr_pkg::ssr_grp_t'(g);
		i_cmd_data <= d;
		do @(posedge i_clock); while (o_cmd_ready !== 1'b1);
		i_cmd_valid <= 1'b0;
	endtask

	task automatic rd(ssr_pkg::ssr_op_t op, int g, logic [15:0] exp, string what);
		cmd(op, g, 16'h0000);
		@(posedge i_clock);
		chk("resp valid", 16'h0001, 16'(o_resp_valid));
		chk(what, exp, o_resp_data);
	endtask

	task automatic wait_poll(logic [7:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_spoll_valid !== 1'b1 && n < 40);
		chk("poll byte", 16'(exp), 16'(o_spoll_data));
		chk("srq after poll", 16'h0000, 16'(o_srq));
	endtask

	task automatic setc(int g, logic [15:0] v);
		case (g)
			0: i_dev_cond <= v;
			1: i_ques_cond <= v;
			2: i_oper_cond <= v;
			default: i_std_cond <= v[7:0];
		endcase
	endtask

	initial begin
		{i_nrst, i_cmd_valid, i_errq_nonempty, i_outq_nonempty, arm} = '0;
		{i_dev_cond, i_ques_cond, i_oper_cond, i_std_cond, i_cmd_data, dly} = '0;
		{i_ce, i_prior_done} = 2'b11;
		i_cmd_op = ssr_pkg::OP_NOP;
		i_cmd_grp = ssr_pkg::GRP_DEV;
		miscompares = 0;
		tests_run = 0;
		cycles = 0;
		tick(6);
		i_nrst <= 1'b1;
		rd(ssr_pkg::OP_SRE_RD, 0, 16'h0000, "sre reset");
		cmd(ssr_pkg::OP_CLS, 0, 16'h0000);
		cmd(ssr_pkg::OP_SRE_WR, 0, 16'h0010);
		rd(ssr_pkg::OP_SRE_RD, 0, 16'h0010, "sre");
		rd(ssr_pkg::OP_SRE_RD, 0, 16'h0010, "sre again");
		arm <= 1'b1;
		i_outq_nonempty <= 1'b1;
		wait_poll(8'h50);
		tick(3);
		chk("srq held off", 16'h0000, 16'(o_srq));
		chk("mav", 16'h0001, 16'(o_status_byte[4]));
		arm <= 1'b0;
		i_outq_nonempty <= 1'b0;
		tick(3);
		chk("mav clear", 16'h0000, 16'(o_status_byte[4]));
		i_outq_nonempty <= 1'b1;
		tick(4);
		chk("srq", 16'h0001, 16'(o_srq));
		i_prior_done <= 1'b0;
		fork
			rd(ssr_pkg::OP_STB_RD, 0, 16'h0050, "stb query");
			begin
				tick(4);
				chk("held query", 16'h0000, 16'(o_resp_valid));
				i_prior_done <= 1'b1;
			end
		join
		chk("srq kept", 16'h0001, 16'(o_srq));
		dly <= 4'h9;
		arm <= 1'b1;
		wait_poll(8'h50);
		arm <= 1'b0;
		i_outq_nonempty <= 1'b0;
		for (int g = 0; g < 4; g++) begin
			cmd(ssr_pkg::OP_EN_WR, g, 16'h0000);
			setc(g, 16'h8001);
			tick(2);
			setc(g, 16'h0000);
			tick(3);
			chk("masked summary", 16'h0000, 16'(o_status_byte[sb[g]]));
			rd(ssr_pkg::OP_COND_RD, g, 16'h0000, "cond");
			cmd(ssr_pkg::OP_EN_WR, g, 16'hFFFF);
			tick(3);
			chk("summary", 16'h0001, 16'(o_status_byte[sb[g]]));
			rd(ssr_pkg::OP_EVT_RD, g, 16'h0001, "event");
			tick(2);
			chk("summary clear", 16'h0000, 16'(o_status_byte[sb[g]]));
			rd(ssr_pkg::OP_EN_RD, g, (g == 3) ? 16'h00FF : 16'h7FFF, "enable");
		end
		setc(1, 16'h0002);
		tick(2);
		setc(1, 16'h0000);
		tick(3);
		chk("ques latched", 16'h0001, 16'(o_status_byte[3]));
		cmd(ssr_pkg::OP_CLS, 0, 16'h0000);
		tick(2);
		chk("ques after clear", 16'h0000, 16'(o_status_byte[3]));
		i_errq_nonempty <= 1'b1;
		tick(3);
		chk("errq", 16'h0001, 16'(o_status_byte[2]));
		i_errq_nonempty <= 1'b0;
		tick(3);
		chk("errq clear", 16'h0000, 16'(o_status_byte[2]));
		// falling-edge filter only: a rise must not latch
		cmd(ssr_pkg::OP_PTR_WR, 1, 16'h0000);
		cmd(ssr_pkg::OP_NTR_WR, 1, 16'h0004);
		setc(1, 16'h0004);
		tick(3);
		chk("rise filtered", 16'h0000, 16'(o_status_byte[3]));
		setc(1, 16'h0000);
		tick(3);
		chk("fall latched", 16'h0001, 16'(o_status_byte[3]));
		rd(ssr_pkg::OP_EVT_RD, 1, 16'h0004, "fall event");
		cmd(ssr_pkg::OP_PRESET, 0, 16'h0000);
		rd(ssr_pkg::OP_EN_RD, 1, 16'h0000, "preset enable");
		rd(ssr_pkg::OP_EN_RD, 3, 16'h00FF, "std enable kept");
		setc(1, 16'h0008);
		tick(2);
		setc(1, 16'h0000);
		tick(3);
		chk("preset masks", 16'h0000, 16'(o_status_byte[3]));
		rd(ssr_pkg::OP_EVT_RD, 1, 16'h0008, "preset ptr");
		cmd(ssr_pkg::OP_SRE_WR, 0, 16'h00A4);
		rd(ssr_pkg::OP_SRE_RD, 0, 16'h00A4, "sre weighted");
		cmd(ssr_pkg::OP_SRE_WR, 0, 16'h0000);
		rd(ssr_pkg::OP_SRE_RD, 0, 16'h0000, "sre zero");
		cmd(ssr_pkg::OP_SRE_WR, 0, 16'h0020);
		// power cycle in mid-run: queues and host are idle here
		i_nrst <= 1'b0;
		tick(2);
		i_nrst <= 1'b1;
		rd(ssr_pkg::OP_SRE_RD, 0, 16'h0000, "sre power cycle");
		cmd(ssr_pkg::OP_NOP, 0, 16'h0000);
		tick(1);
		chk("nop silent", 16'h0000, 16'(o_resp_valid));
		i_ce <= 1'b0;
		tick(2);
		chk("ready idle", 16'h0000, 16'(o_cmd_ready));
		i_ce <= 1'b1;
		tick(2);
		complete_run();
	end
endmodule // testbench
